// ---- rces_addr_step.sv ----
module rces_addr_step
    import rces_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // current address and mode
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [1:0]        step_i,
    input  wire logic              bus16_i,
    // results
    output logic      [ADDR_W-1:0] next_addr_o,
    output logic      [ADDR_W-1:0] bus_addr_o
);

    if (ADDR_W < 2) begin : g_bad_width
        $error("rces_addr_step: ADDR_W must leave room above bit zero");
    end

    logic [ADDR_W-1:0] stride;

    always_comb begin
        stride = bus16_i ? ADDR_W'(2) : ADDR_W'(1);
        if (!step_i[1]) begin
            next_addr_o = addr_i;
        end else if (step_i == STEP_UP) begin
            next_addr_o = addr_i + stride;
        end else begin
            next_addr_o = addr_i - stride;
        end
        bus_addr_o = {addr_i[ADDR_W-1:1], addr_i[0] & ~bus16_i};
    end

endmodule : rces_addr_step

// ---- rces_ctrl_model.sv ----
module rces_ctrl_model
    import rces_pkg::*;
(
    // clock
    input  wire logic        ref_clk_i,
    // word stream toward the sequencer
    output logic             in_valid_o,
    output logic [CMD_W-1:0] in_word_o,
    output logic             in_last_o,
    input  wire logic        in_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // bit 16 marks the last word of a group; bench keeps groups far below 256 bytes
    logic [16:0] fifo_q[$];
    logic        took;

    initial begin
        in_valid_o = 1'b0;
        in_word_o  = 16'h0000;
        in_last_o  = 1'b0;
        took       = 1'b0;
    end

    always @(posedge ref_clk_i) begin
        took <= in_valid_o && in_ready_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // words leave strictly in order, each held until taken
    always @(negedge ref_clk_i) begin
        if (took) begin
            void'(fifo_q.pop_front());
        end
        if (fifo_q.size() > 0) begin
            in_valid_o <= 1'b1;
            in_word_o  <= fifo_q[0][15:0];
            in_last_o  <= fifo_q[0][16];
        end else begin
            // idle line drops valid and inverts the word every cycle
            in_valid_o <= 1'b0;
            in_word_o  <= ~in_word_o;
            in_last_o  <= 1'b0;
        end
    end
endmodule : rces_ctrl_model

// ---- rces_pkg.sv ----
package rces_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // command word layout, msb first: repeat, wait, operation, step, address
    localparam int CMD_W        = 16;
    localparam int CMD_ADDR_W   = 6;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_STEP_LSB = 6;
    localparam int CMD_OP_LSB   = 8;
    localparam int CMD_WAIT_BIT = 11;
    localparam int CMD_REP_LSB  = 12;
    localparam int CMD_REP_W    = 4;
    localparam int GROUP_BYTES  = 256;

    typedef struct packed {
        logic [CMD_REP_W-1:0]  rep;
        logic                  wait_en;
        logic [2:0]            op;
        logic [1:0]            step;
        logic [CMD_ADDR_W-1:0] addr;
    } rces_cmd_t;

    ////////////////////////////////////////////////////////////////////////////
    // operation and step encodings
    localparam logic [2:0] OP_WRITE  = 3'h1;
    localparam logic [2:0] OP_READ   = 3'h2;
    localparam logic [1:0] STEP_UP   = 2'h2;
    localparam logic [1:0] STEP_DOWN = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic RST_DONE = 1'b0;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_WDATA,
        ST_WR_CYC,
        ST_RD_CYC
    } rces_state_t;

endpackage : rces_pkg

// ---- rces_seq.sv ----
module rces_seq
    import rces_pkg::*;
#(
    parameter int ADDR_W = 6,
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              nrst_i,
    // configuration
    input  wire logic              bus16_i,
    // command word stream
    input  wire logic              in_valid_i,
    input  wire logic [DATA_W-1:0] in_word_i,
    input  wire logic              in_last_i,
    output logic                   in_ready_o,
    // peripheral bus
    output logic      [ADDR_W-1:0] bus_addr_o,
    output logic      [DATA_W-1:0] bus_wdata_o,
    output logic                   bus_wr_o,
    output logic                   bus_rd_o,
    input  wire logic              bus_ready_i,
    input  wire logic [DATA_W-1:0] bus_rdata_i,
    // read results
    output logic      [DATA_W-1:0] rd_data_o,
    output logic                   rd_valid_o,
    // status for cyclic exchange
    output logic                   rx_done_o,
    input  wire logic              rx_done_clr_i
);

    if (DATA_W != CMD_W) begin : g_bad_data
        $error("rces_seq: DATA_W must equal the command word width");
    end
    if (ADDR_W < CMD_ADDR_W) begin : g_bad_addr
        $error("rces_seq: ADDR_W too narrow for the command address");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    rces_state_t          state, next_state;
    rces_cmd_t            cmd, next_cmd;
    logic [ADDR_W-1:0]    addr, next_addr;
    logic [CMD_REP_W-1:0] remain, next_remain;
    logic [DATA_W-1:0]    wdata, next_wdata;
    logic [DATA_W-1:0]    rdata, next_rdata;
    logic                 rvalid, next_rvalid;
    logic                 last_seen, next_last_seen;
    logic                 done, next_done;
    logic [ADDR_W-1:0]    stepped_addr;
    logic                 take, cyc_end, cmd_end;
    rces_cmd_t            in_cmd;

    assign in_cmd = rces_cmd_t'(in_word_i);

    rces_addr_step #(
        .ADDR_W (ADDR_W)
    ) u_step (
        .addr_i      (addr),
        .step_i      (cmd.step),
        .bus16_i     (bus16_i),
        .next_addr_o (stepped_addr),
        .bus_addr_o  (bus_addr_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        in_ready_o = (state == ST_CMD) || (state == ST_WDATA);
        bus_wr_o   = (state == ST_WR_CYC);
        bus_rd_o   = (state == ST_RD_CYC);
        take       = in_valid_i && in_ready_o;
        cyc_end    = (bus_wr_o || bus_rd_o) && bus_ready_i;
        cmd_end    = cyc_end && (remain == '0);
    end

    always_comb begin
        next_state     = state;
        next_cmd       = cmd;
        next_addr      = addr;
        next_remain    = remain;
        next_wdata     = wdata;
        next_rdata     = rdata;
        next_rvalid    = 1'b0;
        next_last_seen = last_seen;
        next_done      = done && !rx_done_clr_i;
        unique case (state)
            ST_CMD: begin
                if (take) begin
                    next_cmd       = in_cmd;
                    next_addr      = ADDR_W'(in_cmd.addr);
                    next_remain    = in_cmd.rep;
                    next_last_seen = in_last_i;
                    if (in_cmd.op == OP_WRITE) begin
                        next_state = ST_WDATA;
                    end else if (in_cmd.op == OP_READ) begin
                        next_state = ST_RD_CYC;
                    end else if (in_last_i) begin
                        // unsupported codes run no cycle but still end a group
                        next_done = 1'b1;
                    end
                end
            end
            ST_WDATA: begin
                if (take) begin
                    next_wdata     = in_word_i;
                    next_last_seen = in_last_i;
                    next_state     = ST_WR_CYC;
                end
            end
            ST_WR_CYC, ST_RD_CYC: begin
                if (cyc_end) begin
                    if (state == ST_RD_CYC) begin
                        next_rdata  = bus_rdata_i;
                        next_rvalid = 1'b1;
                    end
                    if (cmd_end) begin
                        next_state = ST_CMD;
                        if (last_seen) begin
                            next_done = 1'b1;
                        end
                    end else begin
                        next_remain = remain - CMD_REP_W'(1);
                        next_addr   = stepped_addr;
                        // a write run needs its own data word first
                        next_state  = (state == ST_WR_CYC) ? ST_WDATA : ST_RD_CYC;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state     <= ST_CMD;
            cmd       <= '0;
            addr      <= '0;
            remain    <= '0;
            wdata     <= '0;
            rdata     <= '0;
            rvalid    <= 1'b0;
            last_seen <= 1'b0;
            done      <= RST_DONE;
        end else begin
            state     <= next_state;
            cmd       <= next_cmd;
            addr      <= next_addr;
            remain    <= next_remain;
            wdata     <= next_wdata;
            rdata     <= next_rdata;
            rvalid    <= next_rvalid;
            last_seen <= next_last_seen;
            done      <= next_done;
        end
    end

    assign bus_wdata_o = wdata;
    assign rd_data_o   = rdata;
    assign rd_valid_o  = rvalid;
    assign rx_done_o   = done;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [CMD_REP_W:0] runs;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            runs <= '0;
        end else if (state == ST_CMD) begin
            runs <= '0;
        end else if (cyc_end) begin
            runs <= runs + (CMD_REP_W+1)'(1);
        end
    end

    a_step_decode: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (cyc_end && !cmd_end)
        |=> addr == (!cmd.step[1] ? $past(addr)
                   : cmd.step == STEP_UP ? $past(addr) + (bus16_i ? ADDR_W'(2) : ADDR_W'(1))
                   : $past(addr) - (bus16_i ? ADDR_W'(2) : ADDR_W'(1))))
        else $error("address step does not follow the step mode");

    a_op_decode: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state == ST_CMD && take && in_cmd.op == OP_READ) |=> bus_rd_o && !bus_wr_o)
        else $error("read code did not start a read cycle");

    a_run_count: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        cmd_end |-> runs == {1'b0, cmd.rep})
        else $error("wrong number of runs for the command");

    a_addr_lsb: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (bus16_i && (bus_wr_o || bus_rd_o)) |-> !bus_addr_o[0])
        else $error("address bit zero driven on a 16-bit bus");

    a_write_data: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state == ST_WDATA && take) |=> bus_wr_o && bus_wdata_o == $past(in_word_i))
        else $error("write did not use the next data word");

    a_one_at_time: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (bus_wr_o || bus_rd_o) |-> !in_ready_o ##0 !(bus_wr_o && bus_rd_o))
        else $error("stream taken while a bus cycle runs");

    a_done_flag: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (cmd_end && last_seen) |=> rx_done_o ##1 (rx_done_o || $past(rx_done_clr_i)))
        else $error("group end did not set the complete flag");

    // an unsupported last word still closes the group
    a_skip_done: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state == ST_CMD && take && in_last_i && in_cmd.op != OP_WRITE
         && in_cmd.op != OP_READ) |=> rx_done_o && in_ready_o)
        else $error("unsupported last word did not set the complete flag");

    a_first_addr: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (state == ST_CMD && take && in_cmd.op == OP_READ)
        |=> addr == ADDR_W'($past(in_cmd.addr)))
        else $error("first run did not use the start address");

endmodule : rces_seq

// ---- remote_cpu_emulation_sequencer_test.sv ----
module remote_cpu_emulation_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rces_pkg::*;

    logic        ref_clk_i, nrst_i, bus16_i, in_valid_i, in_last_i, in_ready_o;
    logic        bus_wr_o, bus_rd_o, bus_ready_i, rd_valid_o, rx_done_o, rx_done_clr_i;
    logic [15:0] in_word_i, bus_wdata_o, bus_rdata_i, rd_data_o;
    logic [5:0]  bus_addr_o;
    logic [22:0] exp_q[$];
    logic [22:0] rd_q[$];
    logic [22:0] e;
    int          err_total, checks, cyc;

    rces_seq #(.ADDR_W(6), .DATA_W(16)) dut_u (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus16_i(bus16_i),
        .in_valid_i(in_valid_i), .in_word_i(in_word_i), .in_last_i(in_last_i),
        .in_ready_o(in_ready_o), .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
        .bus_wr_o(bus_wr_o), .bus_rd_o(bus_rd_o), .bus_ready_i(bus_ready_i),
        .bus_rdata_i(bus_rdata_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .rx_done_o(rx_done_o), .rx_done_clr_i(rx_done_clr_i));

    rces_ctrl_model ctrl_u (
        .ref_clk_i(ref_clk_i), .in_valid_o(in_valid_i), .in_word_o(in_word_i),
        .in_last_o(in_last_i), .in_ready_i(in_ready_o));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] peri_data(logic [5:0] a);
        return {a, 10'h2A5} ^ 16'h5A5A;
    endfunction : peri_data

    function automatic logic [5:0] step_addr(logic [5:0] a, logic [1:0] s, logic b16);
        logic [5:0] inc;
        inc = b16 ? 6'h02 : 6'h01;
        if (s == STEP_UP) return a + inc;
        if (s == STEP_DOWN) return a - inc;
        return a;
    endfunction : step_addr

    task automatic check(input logic [22:0] seen, input logic [22:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // peripheral answers promptly or slowly at random
    always @(negedge ref_clk_i) begin
        bus_ready_i <= ($urandom % 3) != 0;
        bus_rdata_i <= peri_data(bus_addr_o);
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    always @(posedge ref_clk_i) begin
        if (nrst_i && (bus_wr_o || bus_rd_o) && bus_ready_i) begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            check({bus_wr_o, bus_addr_o, bus_wr_o ? bus_wdata_o : 16'h0000}, e, "bus");
            if (bus_rd_o) rd_q.push_back({7'h00, peri_data(e[21:16])});
        end
        if (nrst_i && rd_valid_o) begin
            e = rd_q.size() ? rd_q.pop_front() : 'x;
            check({7'h00, rd_data_o}, e, "read data");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] cmd;
        logic [15:0] d;
        logic [5:0]  a;
        logic [16:0] grp[$];
        int          k;
        void'($urandom(93889));
        nrst_i = 1'b0;
        bus16_i = 1'b0;
        rx_done_clr_i = 1'b0;
        bus_ready_i = 1'b0;
        bus_rdata_i = 16'h0000;
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i) nrst_i = 1'b1;
        for (int g = 0; g < 40; g++) begin
            bus16_i = g[0];
            check({22'h000000, rx_done_o}, 23'h000000, "done idle");
            check({22'h000000, in_ready_o}, 23'h000001, "ready idle");
            k = 1 + $urandom % 3;
            // every op code in one group each, then writes and reads, one group of long repeats
            for (int c = 0; c < k; c++) begin
                cmd = $urandom;
                cmd[10:8] = (g < 8) ? g[2:0] : (($urandom % 2) ? OP_WRITE : OP_READ);
                cmd[15:12] = (g == 9) ? 4'hF : 4'($urandom % 4);
                grp.push_back({1'b0, cmd});
                a = cmd[5:0];
                for (int r = 0; r <= cmd[15:12]; r++) begin
                    d = $urandom;
                    if (cmd[10:8] == OP_WRITE) grp.push_back({1'b0, d});
                    if (cmd[10:8] == OP_WRITE || cmd[10:8] == OP_READ)
                        exp_q.push_back({cmd[10:8] == OP_WRITE, bus16_i ? {a[5:1], 1'b0} : a,
                                         cmd[10:8] == OP_WRITE ? d : 16'h0000});
                    a = step_addr(a, cmd[7:6], bus16_i);
                end
            end
            grp[$][16] = 1'b1;
            // one group holds the clear high so the set must win over it
            rx_done_clr_i = (g == 11);
            foreach (grp[i]) ctrl_u.fifo_q.push_back(grp[i]);
            grp.delete();
            for (int n = 0; n < 2000 && rx_done_o !== 1'b1; n++) @(negedge ref_clk_i);
            rx_done_clr_i = 1'b0;
            repeat (2) @(negedge ref_clk_i);
            check({22'h000000, rx_done_o}, 23'h000001, "done set");
            check(23'(exp_q.size() + rd_q.size()), 23'h000000, "runs left");
            check(23'(ctrl_u.fifo_q.size()), 23'h000000, "words left");
            rx_done_clr_i = 1'b1;
            @(negedge ref_clk_i) rx_done_clr_i = 1'b0;
            @(negedge ref_clk_i);
        end
        tally_and_finish();
    end
endmodule : remote_cpu_emulation_sequencer_test
